//--- hw/vlsu_decode.sv
// Instruction decoder for the vector load/store unit
`timescale 1ns/1ps
`default_nettype none
module vlsu_decode (
  // Instruction word
  input  wire logic [31:0] insn_i,
  // Decoded operation
  output vlsu_pkg::op_e    op_o,
  output logic             hint_o,
  output logic             illegal_o
);
  import vlsu_pkg::*;

  logic [31:0] xk;

  // ==========================================================================
  // Decode
  always_comb begin
    xk        = insn_i & X_FIELD_MASK;
    op_o      = OP_NONE;
    hint_o    = 1'b0;
    illegal_o = 1'b0;
    case (xk)
      OPC_LD_QW:      op_o = OP_LD_QW;
      OPC_LD_QW_HINT: begin
        op_o   = OP_LD_QW;
        hint_o = 1'b1; // [RULE_03]
      end
      OPC_SH_LEFT:    op_o = OP_SH_LEFT;
      OPC_SH_RIGHT:   op_o = OP_SH_RIGHT;
      OPC_MF_STAT:    op_o = OP_MF_STAT;
      OPC_ST_BYTE:    op_o = OP_ST_BYTE;
      OPC_ST_HALF:    op_o = OP_ST_HALF;
      OPC_ST_WORD:    op_o = OP_ST_WORD;
      OPC_ST_LEFT:    op_o = OP_ST_LEFT;
      OPC_ST_LEFT_H:  begin
        op_o   = OP_ST_LEFT;
        hint_o = 1'b1; // [RULE_11]
      end
      OPC_ST_RIGHT:   op_o = OP_ST_RIGHT;
      OPC_ST_RIGHT_H: begin
        op_o   = OP_ST_RIGHT;
        hint_o = 1'b1; // [RULE_14]
      end
      OPC_ST_QW:      op_o = OP_ST_QW;
      default: begin
        if ((insn_i & MT_FIELD_MASK) == (OPC_MT_STAT & MT_FIELD_MASK)) begin
          op_o = OP_MT_STAT; // [RULE_06]
        end else begin
          illegal_o = 1'b1;
        end
      end
    endcase
  end

endmodule : vlsu_decode
`default_nettype wire

//--- hw/vlsu_pkg.sv
// Constants and types for the vector load/store unit
// Operation
// RULE_01: Quadword load: address base plus index, low four bits cleared, load 16 bytes.
// RULE_02: Base register number zero contributes zero instead of its contents.
// RULE_03: Hinted quadword load loads the same quadword and signals not-reused-soon.
// RULE_04: Hint may mark the whole cache block as a preferred victim.
// RULE_05: Move-from-status copies the status register into the destination vector.
// RULE_06: Move-to-status loads status from source bits 96 to 127; fixed encoding.
// RULE_07: Byte element store writes byte lane selected by address bits 60 to 63.
// RULE_08: Halfword element store clears bit 63, writes halfword lane from bits 60-62.
// RULE_09: Word element store clears two low bits, writes word lane from bits 60-61.
// RULE_10: Left-partial store writes leftmost sixteen-minus-offset bytes at the address.
// RULE_11: Hinted left-partial store writes the same and signals not-reused-soon.
// RULE_12: Right-partial store writes rightmost offset bytes at address minus offset.
// RULE_13: Right-partial stores with zero offset perform no memory write.
// RULE_14: Hinted right-partial store behaves the same and signals not-reused-soon.
// RULE_15: Quadword store address is base plus index with low four bits cleared.
// RULE_16: Shift-left/right control vectors select shifted 16 of 32 concatenated bytes.
// RULE_17: Quadword store writes all 16 source bytes to the aligned quadword.
// RULE_18: Shift-left control load gives bytes offset to offset plus 15 of 0x00..0x1f.
// RULE_19: Shift-right control load gives bytes 16-offset to 31-offset of 0x00..0x1f.
// RULE_20: Partial and element stores drive per-byte enables for selected bytes only.
// RULE_21: Move-from-status places status in bits 96-127 and zeroes the rest.
package vlsu_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 64;
  localparam int unsigned VEC_W  = 128;
  localparam int unsigned GPR_W  = 64;
  localparam int unsigned STAT_W = 32;
  localparam int unsigned REGN_W = 5;
  localparam int unsigned QW_BYTES = 16;

  // ==========================================================================
  // Address masks
  localparam logic [ADDR_W-1:0] QW_MASK = 64'hffff_ffff_ffff_fff0;
  localparam logic [ADDR_W-1:0] HW_MASK = 64'hffff_ffff_ffff_fffe;
  localparam logic [ADDR_W-1:0] WD_MASK = 64'hffff_ffff_ffff_fffc;

  // ==========================================================================
  // Instruction encodings with register fields cleared, except bit 11 set in the source field of OPC_MT_STAT
  localparam logic [31:0] OPC_LD_QW      = 32'h7c00_00ce;
  localparam logic [31:0] OPC_LD_QW_HINT = 32'h7c00_02ce;
  localparam logic [31:0] OPC_SH_LEFT    = 32'h7c00_000c;
  localparam logic [31:0] OPC_SH_RIGHT   = 32'h7c00_004c;
  localparam logic [31:0] OPC_MF_STAT    = 32'h1000_0604;
  localparam logic [31:0] OPC_MT_STAT    = 32'h1000_0c44;
  localparam logic [31:0] OPC_ST_BYTE    = 32'h7c00_010e;
  localparam logic [31:0] OPC_ST_HALF    = 32'h7c00_014e;
  localparam logic [31:0] OPC_ST_WORD    = 32'h7c00_018e;
  localparam logic [31:0] OPC_ST_LEFT    = 32'h7c00_050e;
  localparam logic [31:0] OPC_ST_LEFT_H  = 32'h7c00_070e;
  localparam logic [31:0] OPC_ST_RIGHT   = 32'h7c00_054e;
  localparam logic [31:0] OPC_ST_RIGHT_H = 32'h7c00_074e;
  localparam logic [31:0] OPC_ST_QW      = 32'h7c00_01ce;

  // Field masks: X form clears every register field, status move only its source field
  localparam logic [31:0] X_FIELD_MASK  = 32'hfc00_07ff;
  localparam logic [31:0] MT_FIELD_MASK = 32'hffff_07ff;

  // ==========================================================================
  // Reset values
  localparam logic [STAT_W-1:0] STAT_RESET = 32'h0001_0000;

  // ==========================================================================
  // Operation class
  typedef enum logic [3:0] {
    OP_NONE, OP_LD_QW, OP_SH_LEFT, OP_SH_RIGHT, OP_MF_STAT, OP_MT_STAT,
    OP_ST_BYTE, OP_ST_HALF, OP_ST_WORD, OP_ST_LEFT, OP_ST_RIGHT, OP_ST_QW
  } op_e;

endpackage : vlsu_pkg

//--- hw/vlsu_top.sv
// Vector load/store unit: address generation, store lanes, control vectors
`timescale 1ns/1ps
`default_nettype none
module vlsu_top (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // Issue
  input  wire logic                          issue_valid_i,
  input  wire logic [31:0]                   insn_i,
  input  wire logic [vlsu_pkg::GPR_W-1:0]    base_gpr_i,
  input  wire logic [vlsu_pkg::GPR_W-1:0]    index_gpr_i,
  input  wire logic [vlsu_pkg::VEC_W-1:0]    vector_store_source_i,
  input  wire logic [vlsu_pkg::VEC_W-1:0]    vector_source_b_i,
  output logic                               issue_ready_o,
  // Memory request
  output logic                               mem_req_o,
  output logic                               mem_we_o,
  output logic [vlsu_pkg::ADDR_W-1:0]        mem_addr_o,
  output logic [vlsu_pkg::VEC_W-1:0]         mem_wdata_o,
  output logic [vlsu_pkg::QW_BYTES-1:0]      mem_be_o,
  output logic                               mem_hint_o,
  input  wire logic                          mem_ack_i,
  input  wire logic [vlsu_pkg::VEC_W-1:0]    mem_rdata_i,
  // Result
  output logic                               result_valid_o,
  output logic [vlsu_pkg::VEC_W-1:0]         vector_destination_o,
  output logic                               illegal_o,
  output logic [vlsu_pkg::STAT_W-1:0]        vector_status_control_reg_o
);
  import vlsu_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_MEM, S_DONE} state_e;

  // ==========================================================================
  // Decode
  op_e               dec_op;
  logic              dec_hint;
  logic              dec_illegal;
  logic [REGN_W-1:0] base_num;

  vlsu_decode u_decode (
    .insn_i    (insn_i),
    .op_o      (dec_op),
    .hint_o    (dec_hint),
    .illegal_o (dec_illegal)
  );

  assign base_num = insn_i[20:16];

  // ==========================================================================
  // Address and lane computation
  logic [ADDR_W-1:0]   base_val;
  logic [ADDR_W-1:0]   eff_addr;
  logic [3:0]          byte_offset_in_quadword;
  logic [3:0]          byte_rotate_count;
  logic [VEC_W-1:0]    seq_left;
  logic [VEC_W-1:0]    seq_right;
  logic [255:0]        seq_all;

  always_comb begin
    base_val = (base_num == 5'h00) ? '0 : base_gpr_i; // [RULE_02]
    eff_addr = base_val + index_gpr_i;
    byte_offset_in_quadword = eff_addr[3:0];
    byte_rotate_count       = eff_addr[3:0];
  end

  // ==========================================================================
  // Control vector sequence
  // Byte i of the incrementing sequence holds value i, byte 0 most significant
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_seq
      assign seq_all[255-8*gi -: 8] = 8'(gi);
    end
  endgenerate

  always_comb begin
    seq_left  = seq_all[255 - 8*byte_rotate_count -: 128];        // [RULE_18] [RULE_16]
    seq_right = seq_all[255 - 8*(16 - byte_rotate_count) -: 128]; // [RULE_19] [RULE_16]
  end

  // ==========================================================================
  // Request build
  logic                req_nxt;
  logic                we_nxt;
  logic [ADDR_W-1:0]   addr_nxt;
  logic [VEC_W-1:0]    wdata_nxt;
  logic [QW_BYTES-1:0] be_nxt;

  logic                immediate;
  logic [VEC_W-1:0]    imm_data;
  logic                stat_wr;
  logic [4:0]          left_cnt;

  always_comb begin
    req_nxt   = 1'b0;
    we_nxt    = 1'b0;
    addr_nxt  = eff_addr;
    wdata_nxt = vector_store_source_i;
    be_nxt    = '0;
    immediate = 1'b0;
    imm_data  = '0;
    stat_wr   = 1'b0;
    left_cnt  = 5'(QW_BYTES) - {1'b0, byte_offset_in_quadword};

    case (dec_op)
      OP_LD_QW: begin
        req_nxt  = 1'b1;
        addr_nxt = eff_addr & QW_MASK; // [RULE_01]
      end

      OP_SH_LEFT: begin
        immediate = 1'b1;
        imm_data  = seq_left;
      end

      OP_SH_RIGHT: begin
        immediate = 1'b1;
        imm_data  = seq_right;
      end

      OP_MF_STAT: begin
        immediate = 1'b1;
        imm_data  = {96'h0, vector_status_control_reg_o}; // [RULE_05] [RULE_21]
      end

      OP_MT_STAT: begin
        immediate = 1'b1;
        stat_wr   = 1'b1;
      end

      OP_ST_BYTE: begin
        req_nxt  = 1'b1;
        we_nxt   = 1'b1;
        addr_nxt = eff_addr; // [RULE_07]
        be_nxt   = 16'h8000 >> byte_offset_in_quadword; // [RULE_07] [RULE_20]
      end

      OP_ST_HALF: begin
        req_nxt  = 1'b1;
        we_nxt   = 1'b1;
        addr_nxt = eff_addr & HW_MASK; // [RULE_08]
        be_nxt   = 16'hc000 >> {eff_addr[3:1], 1'b0}; // [RULE_08] [RULE_20]
      end

      OP_ST_WORD: begin
        req_nxt  = 1'b1;
        we_nxt   = 1'b1;
        addr_nxt = eff_addr & WD_MASK; // [RULE_09]
        be_nxt   = 16'hf000 >> {eff_addr[3:2], 2'b00}; // [RULE_09] [RULE_20]
      end

      OP_ST_LEFT: begin
        req_nxt   = 1'b1;
        we_nxt    = 1'b1;
        addr_nxt  = eff_addr; // [RULE_10]
        // Leftmost bytes of the source land at the addressed bytes onward
        wdata_nxt = vector_store_source_i >> (8*byte_offset_in_quadword); // [RULE_10]
        be_nxt    = 16'hffff >> byte_offset_in_quadword; // [RULE_10] [RULE_20]
      end

      OP_ST_RIGHT: begin
        we_nxt    = 1'b1;
        req_nxt   = (byte_offset_in_quadword != 4'h0); // [RULE_13]
        addr_nxt  = eff_addr - {60'h0, byte_offset_in_quadword}; // [RULE_12]
        wdata_nxt = vector_store_source_i << (8*left_cnt); // [RULE_12]
        be_nxt    = ~(16'hffff >> byte_offset_in_quadword); // [RULE_12] [RULE_20]
        immediate = (byte_offset_in_quadword == 4'h0); // [RULE_13]
      end

      OP_ST_QW: begin
        req_nxt  = 1'b1;
        we_nxt   = 1'b1;
        addr_nxt = eff_addr & QW_MASK; // [RULE_15]
        be_nxt   = '1; // [RULE_17]
      end

      default: begin
        immediate = dec_illegal;
      end
    endcase
  end

  // ==========================================================================
  // Control state
  state_e            state_r, state_nxt;
  logic              mem_req_r, mem_req_nxt2;
  logic              mem_we_r, mem_we_nxt2;
  logic [ADDR_W-1:0] mem_addr_r, mem_addr_nxt2;
  logic [VEC_W-1:0]  mem_wdata_r, mem_wdata_nxt2;
  logic [QW_BYTES-1:0] mem_be_r, mem_be_nxt2;
  logic              mem_hint_r, mem_hint_nxt2;
  logic              res_valid_r, res_valid_nxt;
  logic [VEC_W-1:0]  res_data_r, res_data_nxt;
  logic              illegal_r, illegal_nxt;
  logic              is_load_r, is_load_nxt;
  logic              take;

  // ==========================================================================
  // Next state
  always_comb begin
    take           = issue_valid_i && (state_r == S_IDLE);

    state_nxt      = state_r;
    mem_req_nxt2   = mem_req_r;
    mem_we_nxt2    = mem_we_r;
    mem_addr_nxt2  = mem_addr_r;
    mem_wdata_nxt2 = mem_wdata_r;
    mem_be_nxt2    = mem_be_r;
    mem_hint_nxt2  = mem_hint_r;
    res_valid_nxt  = 1'b0;
    res_data_nxt   = res_data_r;
    illegal_nxt    = 1'b0;
    is_load_nxt    = is_load_r;

    case (state_r)
      S_IDLE: begin
        if (take) begin
          if (req_nxt) begin
            state_nxt      = S_MEM;
            mem_req_nxt2   = 1'b1;
            mem_we_nxt2    = we_nxt;
            mem_addr_nxt2  = addr_nxt;
            mem_wdata_nxt2 = we_nxt ? wdata_nxt : '0;
            mem_be_nxt2    = we_nxt ? be_nxt : '0;
            mem_hint_nxt2  = dec_hint; // [RULE_03] [RULE_04] [RULE_11] [RULE_14]
            is_load_nxt    = !we_nxt;
          end else if (immediate) begin
            res_valid_nxt = 1'b1;
            res_data_nxt  = imm_data;
            illegal_nxt   = dec_illegal;
          end
        end
      end

      S_MEM: begin
        if (mem_ack_i) begin
          state_nxt     = S_DONE;
          mem_req_nxt2  = 1'b0;
          mem_we_nxt2   = 1'b0;
          mem_hint_nxt2 = 1'b0;
          res_valid_nxt = 1'b1;
          if (is_load_r) begin
            res_data_nxt = mem_rdata_i; // [RULE_01]
          end
        end
      end

      S_DONE: begin
        state_nxt = S_IDLE;
      end

      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r     <= S_IDLE;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= '0;
      mem_wdata_r <= '0;
      mem_be_r    <= '0;
      mem_hint_r  <= 1'b0;
      res_valid_r <= 1'b0;
      res_data_r  <= '0;
      illegal_r   <= 1'b0;
      is_load_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      mem_req_r   <= mem_req_nxt2;
      mem_we_r    <= mem_we_nxt2;
      mem_addr_r  <= mem_addr_nxt2;
      mem_wdata_r <= mem_wdata_nxt2;
      mem_be_r    <= mem_be_nxt2;
      mem_hint_r  <= mem_hint_nxt2;
      res_valid_r <= res_valid_nxt;
      res_data_r  <= res_data_nxt;
      illegal_r   <= illegal_nxt;
      is_load_r   <= is_load_nxt;
    end
  end

  // ==========================================================================
  // Status register
  logic [STAT_W-1:0] stat_r, stat_nxt;

  always_comb begin
    stat_nxt = stat_r;
    if (take && stat_wr) begin
      stat_nxt = vector_source_b_i[31:0]; // [RULE_06]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stat_r <= STAT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ==========================================================================
  // Issue ready, registered so that it tracks the idle state
  logic ready_r, ready_nxt;

  always_comb begin
    ready_nxt = (state_nxt == S_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign issue_ready_o               = ready_r;

  // Memory request
  assign mem_req_o                   = mem_req_r;
  assign mem_we_o                    = mem_we_r;
  assign mem_addr_o                  = mem_addr_r;
  assign mem_wdata_o                 = mem_wdata_r;
  assign mem_be_o                    = mem_be_r;
  assign mem_hint_o                  = mem_hint_r;

  // Result
  assign result_valid_o              = res_valid_r;
  assign vector_destination_o        = res_data_r;
  assign illegal_o                   = illegal_r;
  assign vector_status_control_reg_o = stat_r;

endmodule : vlsu_top
`default_nettype wire

//--- tb/test_vlsu_top.sv
// Self-checking testbench for the vector load/store unit
`timescale 1ns/1ps
`default_nettype none
module test_vlsu_top;
  import vlsu_pkg::*;
  // ==========================================================================
  // Signals
  logic         clk = 1'b0, rst = 1'b1, vld = 1'b0, ack, rv, rdy, req, we, hint, ill, lh;
  logic [31:0]  insn = 32'h0, stat;
  logic [63:0]  base = 64'h0, idx = 64'h0, addr, la;
  logic [127:0] src = 128'h0, vb = 128'h0, rd, wd, dst, lw;
  logic [15:0]  be, lb, cnt;
  logic [3:0]   lat = 4'h0;
  int           errors = 0, total_checks = 0;
  localparam logic [63:0]  B = 64'h1000_0000_0000_0100;
  localparam logic [127:0] S = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  vlsu_top u_dut (.clk_i(clk), .reset_i(rst), .issue_valid_i(vld), .insn_i(insn),
    .base_gpr_i(base), .index_gpr_i(idx), .vector_store_source_i(src),
    .vector_source_b_i(vb), .issue_ready_o(rdy), .mem_req_o(req), .mem_we_o(we),
    .mem_addr_o(addr), .mem_wdata_o(wd), .mem_be_o(be), .mem_hint_o(hint),
    .mem_ack_i(ack), .mem_rdata_i(rd), .result_valid_o(rv), .vector_destination_o(dst),
    .illegal_o(ill), .vector_status_control_reg_o(stat));
  vlsu_mem_model u_mem (.clk_i(clk), .reset_i(rst), .req_i(req), .we_i(we), .addr_i(addr),
    .wdata_i(wd), .be_i(be), .hint_i(hint), .lat_i(lat), .ack_o(ack), .rdata_o(rd),
    .last_addr_o(la), .last_wdata_o(lw), .last_be_o(lb), .last_hint_o(lh), .count_o(cnt));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic finish_test;
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [127:0] bm(input logic [15:0] b);
    for (int k = 0; k < 16; k++) bm[8*k +: 8] = {8{b[k]}};
  endfunction
  function automatic logic [31:0] mk(input logic [31:0] o, input logic [4:0] ra);
    return o | ({27'h0, ra} << 16) | 32'h0000_1000;
  endfunction
  task automatic wt(input logic w);
    int n;
    n = 0;
    while (w == 1'b0 ? rdy !== 1'b1 : rv !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 60) begin
        errors++;
        finish_test();
      end
    end
  endtask
  task automatic op(input logic [31:0] i, input logic [63:0] b, input logic [63:0] x);
    @(posedge clk);
    #1;
    wt(1'b0);
    insn = i; base = b; idx = x; src = S; vld = 1'b1;
    @(posedge clk);
    #1;
    vld = 1'b0;
    wt(1'b1);
  endtask
  task automatic st(input logic [31:0] o, input logic [63:0] a, input logic [15:0] b,
                    input logic [127:0] d, input logic h);
    op(mk(o, 5'd3), B, 64'h25);
    chk(la, {B[63:16], a[15:0]});
    chk(lb, b);
    chk(lw & bm(b), d & bm(b));
    chk(lh, h);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_loads;
    op(mk(OPC_LD_QW, 5'd0), B, 64'h27);
    chk(la, 64'h20);
    chk(dst, {8{16'h0020}});
    chk(lh, 1'b0);
    lat = 4'h7;
    op(mk(OPC_LD_QW_HINT, 5'd3), B, 64'h27);
    chk(la, {B[63:16], 16'h0120});
    chk(dst, {8{16'h0120}});
    chk(lh, 1'b1);
    lat = 4'h0;
  endtask
  task automatic t_stores;
    st(OPC_ST_BYTE, 64'h125, 16'h8000 >> 5, S, 1'b0);
    st(OPC_ST_HALF, 64'h124, 16'hc000 >> 4, S, 1'b0);
    st(OPC_ST_WORD, 64'h124, 16'hf000 >> 4, S, 1'b0);
    lat = 4'h3;
    st(OPC_ST_LEFT, 64'h125, 16'hffff >> 5, S >> 40, 1'b0);
    st(OPC_ST_LEFT_H, 64'h125, 16'hffff >> 5, S >> 40, 1'b1);
    st(OPC_ST_RIGHT, 64'h120, 16'hffff << 11, S << 88, 1'b0);
    st(OPC_ST_RIGHT_H, 64'h120, 16'hffff << 11, S << 88, 1'b1);
    lat = 4'h0;
    st(OPC_ST_QW, 64'h120, 16'hffff, S, 1'b0);
  endtask
  task automatic t_right_zero;
    logic [15:0] c0;
    c0 = cnt;
    op(mk(OPC_ST_RIGHT, 5'd3), B, 64'h20);
    op(mk(OPC_ST_RIGHT_H, 5'd3), B, 64'h20);
    chk(cnt, c0);
  endtask
  task automatic t_shift;
    logic [127:0] el, er;
    for (int s = 0; s < 16; s++) begin
      for (int i = 0; i < 16; i++) begin
        el[127-8*i -: 8] = 8'(s + i);
        er[127-8*i -: 8] = 8'(16 - s + i);
      end
      op(mk(OPC_SH_LEFT, 5'd0), 64'h0, 64'(s));
      chk(dst, el);
      op(mk(OPC_SH_RIGHT, 5'd3), 64'h40, 64'(s));
      chk(dst, er);
    end
  endtask
  task automatic t_status;
    chk(stat, STAT_RESET);
    vb = 128'h1234_5678_9abc_def0_0f0f_f0f0_a5a5_0f0f;
    op(OPC_MT_STAT | 32'h0000_2000, 64'h0, 64'h0);
    chk(stat, 32'ha5a5_0f0f);
    op(OPC_MF_STAT | 32'h0020_0000, 64'h0, 64'h0);
    chk(dst, {96'h0, 32'ha5a5_0f0f});
    op(32'h0, 64'h0, 64'h0);
    chk(ill, 1'b1);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_status();
    t_loads();
    t_stores();
    t_right_zero();
    t_shift();
    finish_test();
  end
endmodule // test_vlsu_top
`default_nettype wire

//--- tb/vlsu_mem_model.sv
// Behavioural memory side answering the unit's requests
`timescale 1ns/1ps
`default_nettype none
module vlsu_mem_model (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          reset_i,
  // Request
  input wire logic          req_i,
  input wire logic          we_i,
  input wire logic [63:0]   addr_i,
  input wire logic [127:0]  wdata_i,
  input wire logic [15:0]   be_i,
  input wire logic          hint_i,
  input wire logic [3:0]    lat_i,
  output logic              ack_o,
  output logic [127:0]      rdata_o,
  // Record of the last completed request
  output logic [63:0]       last_addr_o,
  output logic [127:0]      last_wdata_o,
  output logic [15:0]       last_be_o,
  output logic              last_hint_o,
  output logic [15:0]       count_o
);
  logic [3:0] wait_r;
  // ==========================================================================
  // Ack lat_i cycles after the request is first seen (lat_i+1 after req_i rises); read data is garbage outside the ack cycle
  always_ff @(posedge clk_i) begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (reset_i) begin
      wait_r  <= 4'h0;
      count_o <= 16'h0;
      rdata_o <= 128'h0;
    end else if (req_i && !ack_o) begin
      if (wait_r == lat_i) begin
        ack_o        <= 1'b1;
        wait_r       <= 4'h0;
        rdata_o      <= {8{addr_i[15:0]}};
        count_o      <= count_o + 16'h1;
        last_addr_o  <= addr_i;
        last_wdata_o <= wdata_i;
        last_be_o    <= we_i ? be_i : 16'h0;
        last_hint_o  <= hint_i;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // vlsu_mem_model
`default_nettype wire

//--- tb/vlsu_top_assertions.sv
// Port checker for the vector load/store unit
`timescale 1ns/1ps
`default_nettype none
module vlsu_top_assertions (
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       reset_i,
  // Issue
  input wire logic                       issue_valid_i,
  input wire logic [31:0]                insn_i,
  input wire logic [vlsu_pkg::VEC_W-1:0] vector_source_b_i,
  input wire logic                       issue_ready_o,
  // Memory
  input wire logic                       mem_req_o,
  input wire logic                       mem_we_o,
  input wire logic [vlsu_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [vlsu_pkg::QW_BYTES-1:0] mem_be_o,
  input wire logic                       mem_hint_o,
  input wire logic                       mem_ack_i,
  input wire logic [vlsu_pkg::VEC_W-1:0] mem_rdata_i,
  // Result
  input wire logic                       result_valid_o,
  input wire logic [vlsu_pkg::VEC_W-1:0] vector_destination_o,
  input wire logic [vlsu_pkg::STAT_W-1:0] vector_status_control_reg_o
);
  import vlsu_pkg::*;
  // ==========================================================================
  // Helpers
  logic        take;
  logic [31:0] src_low;
  logic [31:0] opx;
  logic [31:0] opm;
  assign take    = issue_valid_i && issue_ready_o;
  assign src_low = vector_source_b_i[31:0];
  assign opx     = insn_i & X_FIELD_MASK;
  assign opm     = insn_i & MT_FIELD_MASK;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // Properties
  a_load_data: assert property (mem_req_o && mem_ack_i && !mem_we_o |=>
    result_valid_o && vector_destination_o == $past(mem_rdata_i)) else $error("load data lost");
  a_load_aligned: assert property (mem_req_o && !mem_we_o |->
    mem_addr_o[3:0] == 4'h0 && mem_be_o == 16'h0) else $error("load not aligned");
  a_load_issue: assert property (take && opx == OPC_LD_QW |=>
    mem_req_o && !mem_we_o && !mem_hint_o) else $error("load not issued");
  a_load_hint: assert property (take && opx == OPC_LD_QW_HINT |=>
    mem_req_o && mem_hint_o) else $error("load hint missing");
  a_full_store: assert property (mem_req_o && mem_we_o && mem_be_o == 16'hffff |->
    mem_addr_o[3:0] == 4'h0) else $error("full store not aligned");
  a_req_holds: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_be_o)) else $error("request moved");
  a_store_bytes: assert property (mem_req_o && mem_we_o |->
    mem_be_o != 16'h0) else $error("empty store issued");
  a_status_write: assert property (take && opm == (OPC_MT_STAT & MT_FIELD_MASK) |=>
    vector_status_control_reg_o == $past(src_low)) else $error("status not loaded");
  a_status_read: assert property (take && opx == OPC_MF_STAT |=>
    result_valid_o && vector_destination_o == {96'h0, $past(vector_status_control_reg_o)})
    else $error("status not read");
  a_busy_refuse: assert property (mem_req_o |-> !issue_ready_o) else $error("ready while busy");
  a_result_pulse: assert property (result_valid_o |->
    $past(take) || $past(mem_req_o && mem_ack_i)) else $error("result without cause");
endmodule // vlsu_top_assertions
bind vlsu_top vlsu_top_assertions u_chk (.clk_i, .reset_i, .issue_valid_i, .insn_i,
  .vector_source_b_i, .issue_ready_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_be_o,
  .mem_hint_o, .mem_ack_i, .mem_rdata_i, .result_valid_o, .vector_destination_o,
  .vector_status_control_reg_o);
`default_nettype wire
